// ---- hdl/ppmux_consts.svh ----
/*
 Timing counts, field positions and reset values for the parallel port pin mux.
 Assumes a 100 MHz core clock; included by the package and the design files.
*/
`ifndef PPMUX_CONSTS_SVH
`define PPMUX_CONSTS_SVH

`define CLK_MHZ          100
`define ALE_NS           20
`define STROBE_NS        30
`define RECOV_NS         10
// Least times: round up to whole cycles
`define ALE_CYC          ((`ALE_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYC       ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define RECOV_CYC        ((`RECOV_NS * `CLK_MHZ + 999) / 1000)

`define CFG_INT0_BIT     16
`define CFG_INT1_BIT     17
`define CFG_INT2_BIT     18
`define CFG_TIMER_BIT    19
`define CFG_BUSPINS_BIT  20

`define ADDR_W           24
`define DATA_W           16
`define GP_W             4

`define RST_STROBE_N     1'b1
`define RST_ALE          1'b0
`define RST_PULLUP       1'b1

`endif

// ---- hdl/ppmux_pkg.sv ----
/*
 Types of the pin mux: the command word that its FIFO carries and the sequencer states.
 Assumes the constants header sits beside it in hdl/.
*/
`include "ppmux_consts.svh"

package ppmux_pkg;

	typedef struct packed {
		logic                 write;
		logic [`ADDR_W-1:0]   addr;
		logic [`DATA_W-1:0]   data;
	} cmd_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ADDR  = 4'b0010,
		ST_DATA  = 4'b0100,
		ST_RECOV = 4'b1000
	} pp_state_e;

endpackage

// ---- hdl/stream_if.sv ----
/*
 Valid/ready word stream between the pin mux and its FIFO.
 Assumes both ends share one clock.
*/
`timescale 1ns/10ps

interface stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- hdl/word_fifo.sv ----
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps

module word_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Streams
	stream_if.snk     in_s,
	stream_if.src     out_s
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic          not_full_reg;
	logic          not_empty_reg;

	wire           push_fire = in_s.valid & not_full_reg;
	wire           pop_fire  = not_empty_reg & out_s.ready;
	wire [CW-1:0]  count_next = count_reg + CW'(push_fire) - CW'(pop_fire);
	wire [PW-1:0]  wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
	wire [PW-1:0]  rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

	assign in_s.ready  = not_full_reg;
	assign out_s.valid = not_empty_reg;
	assign out_s.data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge sys_clk) begin
		if (push_fire) begin
			mem_reg[wr_ptr_reg] <= in_s.data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			not_full_reg  <= 1'b1;
			not_empty_reg <= 1'b0;
		end else begin
			if (push_fire) wr_ptr_reg <= wr_ptr_next;
			if (pop_fire) rd_ptr_reg <= rd_ptr_next;
			count_reg     <= count_next;
			not_full_reg  <= (count_next != CW'(DEPTH));
			not_empty_reg <= (count_next != '0);
		end
	end

endmodule

// ---- hdl/parallel_port_and_flag_pin_mux.sv ----
/*
 Parallel port sequencer and general pin mux: multiplexed address/data pins,
 address latch and read/write strobes, plus four general pins with routing.
 Assumes one 100 MHz core clock; pin inputs are asynchronous and synchronised here;
 the external memory latches the address on the address-latch strobe.
*/
// How it works
// [RQ1] Transfers run 8 or 16 bits wide over the same sixteen shared pins.
// [RQ2] Address-latch strobe marks address phase; otherwise the shared pins carry data.
// [RQ3] 8-bit mode: strobe issued when upper location bits change; memory latches them.
// [RQ4] 16-bit mode: strobe issued when lower location bits change; memory latches them.
// [RQ5] Read strobe driven low while external data is being read.
// [RQ6] Write strobe driven low while external data is being written.
// [RQ7] Address-latch strobe accompanies every new address placed on the pins.
// [RQ8] Latch strobe is active high after reset; software may select active low.
// [RQ9] In and after reset read/write strobes high, latch strobe low.
// [RQ10] In and after reset shared pins float with pull-ups enabled.
// [RQ11] Config bit 20 with port disabled turns shared pins into general pins.
// [RQ12] In general-pin use all three strobes stay deasserted.
// [RQ13] Input channel 0 may take shared pins as parallel input data.
// [RQ14] Four general pins each input or output; inputs readable as condition.
// [RQ15] As SPI master any general pin may drive the slave select.
// [RQ16] SPI master boot puts the slave select on general pin zero.
// [RQ17] Config bits 16-18 route general pins 0-2 to external interrupts 0-2.
// [RQ18] Config bit 19 drives general pin 3 with the system timer expiry.
// [RQ19] Asynchronous pin inputs pass two flip-flops before use.
`timescale 1ns/10ps
`include "ppmux_consts.svh"

module parallel_port_and_flag_pin_mux
	import ppmux_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Configuration
	input  wire logic [31:0]         system_config_reg,
	input  wire logic                par_port_enable,
	input  wire logic                wide_mode,
	input  wire logic                ale_active_low,
	input  wire logic                spi_master_mode,
	input  wire logic                spi_boot_mode,
	input  wire logic                spi_select_n,
	input  wire logic [`GP_W-1:0]    spi_select_mask,
	input  wire logic                timer_expired,
	input  wire logic [`GP_W-1:0]    general_pins_dir,
	input  wire logic [`GP_W-1:0]    general_pins_drive,
	input  wire logic [`DATA_W-1:0]  bus_general_pins_dir,
	input  wire logic [`DATA_W-1:0]  bus_general_pins_drive,
	input  wire logic                input_data_channel_port_ch0_en,
	// Transfer requests
	input  wire logic                cmd_valid,
	input  wire logic                cmd_write,
	input  wire logic [`ADDR_W-1:0]  cmd_addr,
	input  wire logic [`DATA_W-1:0]  cmd_wdata,
	output wire logic                cmd_ready,
	output logic      [`DATA_W-1:0]  rd_data,
	output logic                     rd_valid,
	// Parallel port pins
	input  wire logic [`DATA_W-1:0]  muxed_location_value_bus_in,
	output logic      [`DATA_W-1:0]  muxed_location_value_bus_out,
	output logic      [`DATA_W-1:0]  muxed_location_value_bus_oe,
	output logic                     muxed_pullup_en,
	output logic                     ale,
	output logic                     rd_n,
	output logic                     wr_n,
	// Shared pins in general use
	output logic      [`DATA_W-1:0]  bus_general_pins_in,
	output logic      [`DATA_W-1:0]  input_data_channel_port_data,
	output logic                     input_data_channel_port_valid,
	// General pins
	input  wire logic [`GP_W-1:0]    general_pins_in,
	output logic      [`GP_W-1:0]    general_pins_out,
	output logic      [`GP_W-1:0]    general_pins_oe,
	output logic      [`GP_W-1:0]    general_pins_cond,
	output logic                     ext_interrupt_zero,
	output logic                     ext_interrupt_one,
	output logic                     ext_interrupt_two
);

	localparam int           CMD_W      = $bits(cmd_s);
	localparam logic [3:0]   ALE_LAST   = 4'(`ALE_CYC - 1);
	localparam logic [3:0]   STRB_LAST  = 4'(`STROBE_CYC - 1);
	localparam logic [3:0]   RECOV_LAST = 4'(`RECOV_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [`DATA_W-1:0] bus_s1_reg;
	logic [`DATA_W-1:0] bus_s2_reg;
	logic [`GP_W-1:0]   gp_s1_reg;
	logic [`GP_W-1:0]   gp_s2_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_s1_reg <= '0;
			bus_s2_reg <= '0;
			gp_s1_reg  <= '0;
			gp_s2_reg  <= '0;
		end else begin
			bus_s1_reg <= muxed_location_value_bus_in; // RQ19
			bus_s2_reg <= bus_s1_reg; // RQ19
			gp_s1_reg  <= general_pins_in; // RQ19
			gp_s2_reg  <= gp_s1_reg; // RQ19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command FIFO

	stream_if #(.W(CMD_W)) push_s ();
	stream_if #(.W(CMD_W)) pop_s ();

	assign push_s.valid = cmd_valid;
	assign push_s.data  = {cmd_write, cmd_addr, cmd_wdata};
	assign cmd_ready    = push_s.ready;

	word_fifo #(
		.W     (CMD_W),
		.DEPTH (FIFO_DEPTH)
	) u_cmd_fifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.in_s    (push_s),
		.out_s   (pop_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer

	pp_state_e           state_reg;
	pp_state_e           state_next;
	cmd_s                cmd_reg;
	logic [3:0]          cnt_reg;
	logic [`DATA_W-1:0]  lat_reg;
	logic                lat_wide_reg;
	logic                lat_valid_reg;

	wire                 bus_pins_mode = system_config_reg[`CFG_BUSPINS_BIT] & ~par_port_enable; // RQ11
	cmd_s                pop_cmd;
	assign pop_cmd       = cmd_s'(pop_s.data);
	assign pop_s.ready   = (state_reg == ST_IDLE) & ~bus_pins_mode;
	wire                 pop_fire = pop_s.valid & pop_s.ready;

	// Field that the external latch holds in each width
	wire [`DATA_W-1:0]   lat_field = wide_mode ? pop_cmd.addr[15:0] : pop_cmd.addr[23:8]; // RQ3 RQ4
	wire                 need_ale  = ~lat_valid_reg | (lat_wide_reg != wide_mode) |
	                                 (lat_field != lat_reg); // RQ7
	wire                 cnt_done  = (state_reg == ST_ADDR)  ? (cnt_reg == ALE_LAST) :
	                                 (state_reg == ST_DATA)  ? (cnt_reg == STRB_LAST) :
	                                 (state_reg == ST_RECOV) ? (cnt_reg == RECOV_LAST) : 1'b0;
	cmd_s                cmd_next;
	assign cmd_next      = pop_fire ? pop_cmd : cmd_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (pop_fire) state_next = need_ale ? ST_ADDR : ST_DATA; // RQ2
			end
			ST_ADDR: begin
				if (cnt_done) state_next = ST_DATA;
			end
			ST_DATA: begin
				if (cnt_done) state_next = ST_RECOV;
			end
			ST_RECOV: begin
				if (cnt_done) state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Switching the pins away aborts a transfer so no strobe is left active
		if (bus_pins_mode) state_next = ST_IDLE; // RQ12
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			cnt_reg       <= '0;
			cmd_reg       <= '0;
			lat_reg       <= '0;
			lat_wide_reg  <= 1'b0;
			lat_valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg   <= cmd_next;
			cnt_reg   <= (state_next != state_reg) ? 4'h0 : cnt_reg + 4'h1;
			if (pop_fire && need_ale) begin
				lat_reg       <= lat_field; // RQ3 RQ4
				lat_wide_reg  <= wide_mode;
				lat_valid_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive, registered from the next state

	wire                 nx_addr  = (state_next == ST_ADDR);
	wire                 nx_data  = (state_next == ST_DATA);
	wire [`DATA_W-1:0]   addr_pin = lat_wide_reg ? cmd_next.addr[15:0] : cmd_next.addr[23:8];
	wire [`DATA_W-1:0]   addr_nx  = (pop_fire & need_ale) ? lat_field : addr_pin;
	// 8-bit data phase carries the low location byte beside the data byte
	wire [`DATA_W-1:0]   data_pin = wide_mode ? cmd_next.data :
	                                {cmd_next.addr[7:0], cmd_next.data[7:0]}; // RQ1
	wire [`DATA_W-1:0]   out_nx   = bus_pins_mode ? bus_general_pins_drive :
	                                nx_addr ? addr_nx : data_pin; // RQ2 RQ11
	wire [`DATA_W-1:0]   oe_nx    = bus_pins_mode ? bus_general_pins_dir :
	                                (nx_addr | (nx_data & cmd_next.write)) ? 16'hFFFF : 16'h0000;
	wire                 rd_fire  = (state_reg == ST_DATA) & cnt_done & ~cmd_reg.write;
	wire [`DATA_W-1:0]   rd_word  = lat_wide_reg ? bus_s2_reg : {8'h00, bus_s2_reg[7:0]}; // RQ1

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			muxed_location_value_bus_out <= '0;
			muxed_location_value_bus_oe  <= '0; // RQ10
			muxed_pullup_en              <= `RST_PULLUP; // RQ10
			ale                          <= `RST_ALE; // RQ9
			rd_n                         <= `RST_STROBE_N; // RQ9
			wr_n                         <= `RST_STROBE_N; // RQ9
			rd_data                      <= '0;
			rd_valid                     <= 1'b0;
		end else begin
			muxed_location_value_bus_out <= out_nx;
			muxed_location_value_bus_oe  <= oe_nx;
			muxed_pullup_en              <= `RST_PULLUP;
			ale                          <= nx_addr ^ ale_active_low; // RQ8 RQ7
			rd_n                         <= ~(nx_data & ~cmd_next.write); // RQ5 RQ12
			wr_n                         <= ~(nx_data & cmd_next.write); // RQ6 RQ12
			rd_valid                     <= rd_fire & ~bus_pins_mode;
			if (rd_fire) rd_data <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared pins in general use and general pins

	wire [`GP_W-1:0] route_int = {1'b0, system_config_reg[`CFG_INT2_BIT],
	                              system_config_reg[`CFG_INT1_BIT],
	                              system_config_reg[`CFG_INT0_BIT]}; // RQ17
	wire [`GP_W-1:0] route_tmr = {system_config_reg[`CFG_TIMER_BIT], 3'b000}; // RQ18
	wire [`GP_W-1:0] sel_pins  = {3'b000, spi_boot_mode} |
	                             (spi_master_mode ? spi_select_mask : 4'h0); // RQ15 RQ16
	wire [`GP_W-1:0] gp_oe_nx  = ~route_int & (route_tmr | sel_pins | general_pins_dir); // RQ14
	wire [`GP_W-1:0] gp_out_nx = (route_tmr & {`GP_W{timer_expired}}) |
	                             (~route_tmr & sel_pins & {`GP_W{spi_select_n}}) |
	                             (~route_tmr & ~sel_pins & general_pins_drive);
	wire             chan_ok   = input_data_channel_port_ch0_en & bus_pins_mode &
	                             (bus_general_pins_dir == 16'h0000); // RQ13

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			general_pins_out              <= '0;
			general_pins_oe               <= '0;
			general_pins_cond             <= '0;
			ext_interrupt_zero            <= 1'b0;
			ext_interrupt_one             <= 1'b0;
			ext_interrupt_two             <= 1'b0;
			bus_general_pins_in           <= '0;
			input_data_channel_port_data  <= '0;
			input_data_channel_port_valid <= 1'b0;
		end else begin
			general_pins_out              <= gp_out_nx;
			general_pins_oe               <= gp_oe_nx;
			general_pins_cond             <= gp_s2_reg; // RQ14
			ext_interrupt_zero            <= route_int[0] & gp_s2_reg[0]; // RQ17
			ext_interrupt_one             <= route_int[1] & gp_s2_reg[1]; // RQ17
			ext_interrupt_two             <= route_int[2] & gp_s2_reg[2]; // RQ17
			bus_general_pins_in           <= bus_s2_reg; // RQ11
			input_data_channel_port_data  <= bus_s2_reg; // RQ13
			input_data_channel_port_valid <= chan_ok; // RQ13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Synchronised paths hold stale reset values for the first cycles
	logic [1:0] warm_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) warm_reg <= 2'h0;
		else if (warm_reg != 2'h3) warm_reg <= warm_reg + 2'h1;
	end
	wire warm = (warm_reg == 2'h3);

	AST_NEW_ADDR_LATCH: assert property (@(posedge sys_clk) disable iff (rst) // RQ3 RQ4 RQ7
		(pop_fire && need_ale && !bus_pins_mode) |=> (state_reg == ST_ADDR) && ale == !$past(ale_active_low))
		else $error("new address without latch strobe");
	AST_SAME_ADDR_SKIP: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
		(pop_fire && !need_ale && !bus_pins_mode) |=> (state_reg == ST_DATA))
		else $error("latch strobe repeated for unchanged address");
	AST_ADDR_PHASE_DRIVE: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
		(state_reg == ST_ADDR) |-> (muxed_location_value_bus_oe == 16'hFFFF) &&
		(muxed_location_value_bus_out == lat_reg))
		else $error("address phase not driving latched field");
	AST_READ_STROBE: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
		(state_reg == ST_DATA && !cmd_reg.write) |-> !rd_n && wr_n &&
		(muxed_location_value_bus_oe == 16'h0000))
		else $error("read strobe wrong in read data phase");
	AST_WRITE_STROBE: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
		(state_reg == ST_DATA && cmd_reg.write) |-> !wr_n && rd_n)
		else $error("write strobe wrong in write data phase");
	AST_NARROW_DATA: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
		(state_reg == ST_DATA && cmd_reg.write && !$past(wide_mode)) |->
		muxed_location_value_bus_out == {cmd_reg.addr[7:0], cmd_reg.data[7:0]})
		else $error("8-bit data phase layout wrong");
	AST_BUS_PINS_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // RQ12
		bus_pins_mode |=> rd_n && wr_n && (ale == $past(ale_active_low)))
		else $error("strobe active while shared pins in general use");
	AST_IDLE_PINS: assert property (@(posedge sys_clk) disable iff (rst) // RQ9 RQ10
		(state_reg == ST_IDLE && !$past(bus_pins_mode)) |-> rd_n && wr_n &&
		muxed_pullup_en && (muxed_location_value_bus_oe == 16'h0000))
		else $error("idle pins not released");
	AST_INT_ROUTE: assert property (@(posedge sys_clk) disable iff (rst) // RQ17 RQ19
		(warm && $past(route_int[0])) |-> !general_pins_oe[0] &&
		(ext_interrupt_zero == $past(general_pins_in[0], 3)))
		else $error("interrupt zero not routed from pin zero");
	AST_TIMER_OUT: assert property (@(posedge sys_clk) disable iff (rst) // RQ18
		$past(route_tmr[3]) |-> general_pins_oe[3] &&
		(general_pins_out[3] == $past(timer_expired)))
		else $error("timer expiry not on pin 3");
	AST_BOOT_SELECT: assert property (@(posedge sys_clk) disable iff (rst) // RQ16
		$past(spi_boot_mode && !route_int[0]) |-> general_pins_oe[0] &&
		(general_pins_out[0] == $past(spi_select_n)))
		else $error("boot select not on pin zero");
	AST_COND_SYNC: assert property (@(posedge sys_clk) disable iff (rst) // RQ14 RQ19
		warm |-> (general_pins_cond == $past(general_pins_in, 3)))
		else $error("general pin condition not three cycles behind pin");

	COV_WIDE_WRITE: cover property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_DATA && cmd_reg.write && lat_wide_reg);
	COV_NARROW_READ: cover property (@(posedge sys_clk) disable iff (rst)
		rd_fire && !lat_wide_reg);
	COV_FIFO_FULL: cover property (@(posedge sys_clk) disable iff (rst) !cmd_ready);
	COV_BUS_PINS: cover property (@(posedge sys_clk) disable iff (rst)
		input_data_channel_port_valid);

endmodule

// ---- tb/ext_latch_mem.sv ----
/*
 External memory with an address latch on the shared pins.
 Assumes pin mux strobes on sys_clk; released pins rise through the pull-ups.
*/
`timescale 1ns/10ps

module ext_latch_mem (
	// Clock
	input  wire logic        sys_clk,
	// Strobes and shared pins
	input  wire logic        ale,
	input  wire logic        ale_active_low,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [15:0] dev_out,
	input  wire logic [15:0] dev_oe,
	// Other drivers on the pins in general use
	input  wire logic [15:0] ext_val,
	input  wire logic        ext_en,
	output wire logic [15:0] pins
);
	logic [15:0] lat_reg;
	logic [15:0] mem [16];
	// Polarity as the pin mux last applied it; the live input leads it by an edge
	logic        pol_reg = 1'b0;
	wire         latch_on = ale ^ pol_reg;
	wire  [15:0] far_val  = !rd_n ? mem[lat_reg[3:0]] : (ext_en ? ext_val : 16'hFFFF);

	assign pins = (dev_oe & dev_out) | (~dev_oe & far_val);
	always @(posedge sys_clk) begin
		pol_reg <= ale_active_low;
		if (latch_on)
			lat_reg <= pins;
		if (!wr_n)
			mem[lat_reg[3:0]] <= pins;
	end
endmodule

// ---- tb/tb_parallel_port_and_flag_pin_mux.sv ----
/*
 Self-checking bench of the pin mux: transfers, latch strobe, general use.
 Assumes ext_latch_mem as the far side and the constants header in hdl/.
*/
`timescale 1ns/10ps
`include "ppmux_consts.svh"
`define CHK(act, exp) begin \
	comparisons++; \
	if ((act) !== (exp)) begin \
		fail_count++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); \
	end \
end

module tb_parallel_port_and_flag_pin_mux;
	logic sys_clk, rst, par_port_enable, wide_mode, ale_active_low, spi_master_mode;
	logic spi_boot_mode, spi_select_n, timer_expired, cmd_valid, cmd_write, ext_en;
	logic input_data_channel_port_ch0_en;
	logic [31:0] system_config_reg;
	logic [3:0]  spi_select_mask, general_pins_dir, general_pins_drive, gp_far;
	logic [15:0] bus_general_pins_dir, bus_general_pins_drive, cmd_wdata, ext_val;
	logic [23:0] cmd_addr;
	wire cmd_ready, rd_valid, muxed_pullup_en, ale, rd_n, wr_n, input_data_channel_port_valid;
	wire ext_interrupt_zero, ext_interrupt_one, ext_interrupt_two;
	wire [15:0] rd_data, muxed_location_value_bus_out, muxed_location_value_bus_oe, pins;
	wire [15:0] bus_general_pins_in, input_data_channel_port_data;
	wire [3:0]  general_pins_out, general_pins_oe, general_pins_cond, general_pins_in;
	int fail_count = 0, comparisons = 0, ale_cnt = 0, wr_cyc = 0;
	logic ale_prev = 1'b0;
	logic ale_pol  = 1'b0;

	// Pad level: driven by whichever side enables it
	assign general_pins_in = (general_pins_oe & general_pins_out) | (~general_pins_oe & gp_far);

	parallel_port_and_flag_pin_mux u_dut (.muxed_location_value_bus_in(pins), .*);
	ext_latch_mem u_mem (.sys_clk(sys_clk), .ale(ale), .ale_active_low(ale_active_low),
		.rd_n(rd_n), .wr_n(wr_n), .dev_out(muxed_location_value_bus_out),
		.dev_oe(muxed_location_value_bus_oe), .ext_val(ext_val), .ext_en(ext_en), .pins(pins));

	always #5 sys_clk = ~sys_clk;
	// Strobe bookkeeping; polarity lags a cycle so a switch is no false strobe
	always @(posedge sys_clk) begin
		ale_pol  <= ale_active_low;
		ale_prev <= ale ^ ale_pol;
		if ((ale ^ ale_pol) && !ale_prev)
			ale_cnt++;
		if (wr_n === 1'b0)
			wr_cyc++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		tally_and_finish();
	endtask
	// Leaves the bench at a falling edge, outputs settled
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic send(input logic wr, input logic [23:0] a, input logic [15:0] d);
		int n;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr  <= a;
		cmd_wdata <= d;
		for (n = 0; n < 60; n++) begin
			@(negedge sys_clk);
			if (cmd_ready === 1'b1)
				break;
		end
		if (n == 60)
			hang();
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic rd_chk(input logic [23:0] a, input logic [15:0] e);
		int n;
		send(1'b0, a, 16'h0000);
		for (n = 0; n < 30; n++) begin
			@(negedge sys_clk);
			if (rd_valid === 1'b1)
				break;
		end
		if (n == 30)
			hang();
		`CHK(rd_data, e)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_clk, rst, cmd_valid, cmd_write, ext_en} = 5'b01000;
		{par_port_enable, wide_mode, ale_active_low, spi_master_mode} = 4'b1100;
		{spi_boot_mode, spi_select_n, timer_expired, input_data_channel_port_ch0_en} = 4'b0100;
		{system_config_reg, cmd_addr, cmd_wdata} = '0;
		{spi_select_mask, general_pins_dir, general_pins_drive, gp_far} = '0;
		{bus_general_pins_dir, bus_general_pins_drive, ext_val} = '0;
		wt(3);
		`CHK({rd_n, wr_n, ale, muxed_location_value_bus_oe}, {3'b110, 16'h0000})
		`CHK(muxed_pullup_en, 1'b1)
		@(posedge sys_clk);
		rst <= 1'b0;
		wt(3);
		`CHK({rd_n, wr_n, ale, muxed_location_value_bus_oe}, {3'b110, 16'h0000})
		// 16-bit: only a low-half change forces a new address phase
		send(1'b1, 24'h000005, 16'hA5C3);
		wt(12);
		`CHK(ale_cnt, 1)
		`CHK(wr_cyc, `STROBE_CYC)
		rd_chk(24'h000005, 16'hA5C3);
		send(1'b1, 24'h010005, 16'h1234);
		wt(12);
		`CHK(ale_cnt, 1)
		// 8-bit: upper bits latched, low byte rides with data
		@(posedge sys_clk);
		wide_mode <= 1'b0;
		send(1'b1, 24'h123406, 16'h0077);
		send(1'b1, 24'h123407, 16'h0088);
		wt(24);
		`CHK(ale_cnt, 2)
		`CHK(u_mem.mem[4], 16'h0788)
		rd_chk(24'h123507, 16'h0034);
		`CHK(ale_cnt, 3)
		// Inverted latch strobe
		@(posedge sys_clk);
		{ale_active_low, wide_mode} <= 2'b11;
		wt(2);
		`CHK(ale, 1'b1)
		send(1'b1, 24'h000009, 16'h0F0F);
		wt(12);
		`CHK({ale_cnt, u_mem.mem[9]}, {32'd4, 16'h0F0F})
		// General use stalls the queue: fill it until refused
		@(posedge sys_clk);
		{ale_active_low, par_port_enable, ext_en, input_data_channel_port_ch0_en} <= 4'b0011;
		system_config_reg <= 32'h0010_0000;
		{bus_general_pins_dir, bus_general_pins_drive, ext_val} <= {16'h00FF, 16'h005A, 16'hC3C3};
		for (int i = 0; i < 4; i++)
			send(1'b1, 24'(i), 16'h0100 + 16'(i));
		wt(4);
		`CHK(cmd_ready, 1'b0)
		`CHK({rd_n, wr_n, ale, wr_cyc}, {3'b110, 32'(5 * `STROBE_CYC)})
		`CHK({muxed_location_value_bus_oe, bus_general_pins_in}, {16'h00FF, 16'hC35A})
		@(posedge sys_clk);
		bus_general_pins_dir <= 16'h0000;
		wt(4);
		`CHK({input_data_channel_port_valid, input_data_channel_port_data}, {1'b1, 16'hC3C3})
		@(posedge sys_clk);
		{par_port_enable, ext_en} <= 2'b10;
		system_config_reg <= 32'h0;
		wt(45);
		`CHK({cmd_ready, wr_cyc}, {1'b1, 32'(9 * `STROBE_CYC)})
		for (int i = 0; i < 4; i++)
			`CHK(u_mem.mem[i], 16'h0100 + 16'(i))
		// General pins: plain use, routing, timer, select
		@(posedge sys_clk);
		{gp_far, general_pins_dir, general_pins_drive} <= {4'hA, 4'h1, 4'h1};
		wt(5);
		`CHK({general_pins_oe, general_pins_cond}, {4'h1, 4'hB})
		@(posedge sys_clk);
		system_config_reg <= 32'h000F_0000;
		timer_expired <= 1'b1;
		wt(5);
		`CHK({ext_interrupt_two, ext_interrupt_one, ext_interrupt_zero}, 3'b010)
		`CHK({general_pins_oe[3], general_pins_out[3]}, 2'b11)
		@(posedge sys_clk);
		{gp_far, timer_expired} <= {4'h5, 1'b0};
		wt(2);
		`CHK(ext_interrupt_zero, 1'b0)
		wt(2);
		`CHK({ext_interrupt_two, ext_interrupt_one, ext_interrupt_zero}, 3'b101)
		`CHK(general_pins_out[3], 1'b0)
		@(posedge sys_clk);
		system_config_reg <= 32'h0;
		{spi_boot_mode, spi_select_n} <= 2'b10;
		wt(3);
		`CHK({general_pins_oe[0], general_pins_out[0]}, 2'b10)
		@(posedge sys_clk);
		{spi_boot_mode, spi_master_mode, spi_select_n, spi_select_mask} <= {3'b011, 4'h4};
		wt(3);
		`CHK({general_pins_oe[2], general_pins_out[2]}, 2'b11)
		tally_and_finish();
	end
endmodule
